// ==== rtl/usbepr_top.sv ====
// Endpoint and frame register block of a USB device controller
`timescale 1ns/10ps
module usbepr_top #(
  parameter int NUM_EP = usbepr_pkg::NUM_ENDPOINTS
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  // Avalon-MM slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // USB engine side: frame start from the packet decoder, qualified
  // by its CRC result and frame number in the same cycle
  input wire logic sof_valid,
  input wire logic sof_crc_bad,
  input wire logic [10:0] sof_frame,
  // Endpoint event pulses, all qualified by ev_ep
  input wire logic [2:0] ev_ep,
  input wire logic ev_setup,
  input wire logic ev_setup_dir_in,
  input wire logic ev_bank_filled,
  input wire logic ev_bank_freed,
  input wire logic ev_toggle,
  input wire logic ev_toggle_valid,
  input wire logic ev_overrun,
  input wire logic ev_starve,
  // Bus reset is a level; it clears enables on every cycle it stands without a control write
  input wire logic usb_bus_reset,
  // Engine-facing outputs, each a flip-flop
  output logic frame_start_flag,
  output logic [6:0] endpoint_fifo_clear,
  output logic [6:0] stall_active,
  output logic [6:0] toggle_zero_req,
  output logic [6:0] bank_release,
  output logic [6:0] ep_enabled
);
  import usbepr_pkg::*;

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  // Frame tracking
  logic [10:0] frame_number_q;
  logic frame_crc_error_q;
  logic frame_start_q;
  // Global endpoint registers
  logic [2:0] endpoint_select_q;
  logic [6:0] fifo_clear_q;
  // Per-endpoint control, one bit or field for each endpoint
  logic [NUM_EP-1:0] stall_q;
  logic [NUM_EP-1:0] toggle_zero_q;
  logic [NUM_EP-1:0] enable_q;
  // Per-endpoint configuration
  logic [1:0] kind_q [NUM_EP];
  logic [NUM_EP-1:0] dir_q;
  logic [2:0] capacity_q [NUM_EP];
  logic [1:0] banks_q [NUM_EP];
  logic [NUM_EP-1:0] claim_q;
  logic [NUM_EP-1:0] cfg_ok_q;
  // Per-endpoint status kept by the engine events
  logic [NUM_EP-1:0] overrun_q;
  logic [NUM_EP-1:0] starve_q;
  logic [NUM_EP-1:0] toggle_q;
  logic [1:0] busy_q [NUM_EP];
  logic [NUM_EP-1:0] ctrl_dir_q;
  logic [NUM_EP-1:0] active_bank_q;
  logic [NUM_EP-1:0] handover_q;
  logic [NUM_EP-1:0] release_q;
  // Bus side: registered read data and waitrequest
  logic [31:0] rdata_q;
  logic wait_q;

  // Access is taken in one cycle; waitrequest drops for a single cycle.
  // A request seen with waitrequest high loads read data; a write lands
  // on the following edge, where the master samples waitrequest low, so
  // a master that gives up early never leaves a half-done write behind.
  // Only byte lane 0 carries register bits; the upper lanes read zero.
  logic acc;
  logic wr;
  logic [7:0] wd;
  logic [2:0] sel;
  assign acc = (avs_read | avs_write) & wait_q;
  assign wr = avs_write & ~wait_q & avs_byteenable[0];
  assign wd = avs_writedata[7:0];
  assign sel = endpoint_select_q;

  // Configuration fits: size within limits for this endpoint and bank
  // count legal, and the bank memory within the whole FIFO.
  // Each endpoint is checked on its own against the whole FIFO; the sum
  // over all claimed endpoints is not tracked, so software must still
  // keep the total within the shared memory.
  function automatic logic cfg_fits(input logic [2:0] ep,
                                    input logic [2:0] cap,
                                    input logic [1:0] bk);
    logic [2:0] lim;
    logic [11:0] bytes;
    lim = (ep == BIG_ENDPOINT) ? CAPACITY_MAX_BIG : CAPACITY_MAX_ANY;
    bytes = 12'(12'h8 << cap) << bk[0];
    cfg_fits = (cap <= lim) && !bk[1] && (int'(bytes) <= FIFO_BYTES);
  endfunction : cfg_fits

  // ----------------------------------------------------------------------
  // Frame number tracking
  // ----------------------------------------------------------------------
  // Loaded on every SOF, good CRC or not
  // The CRC flag moves with the start flag so both read as one event
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      frame_number_q <= 11'h000;
      frame_crc_error_q <= 1'b0;
      frame_start_q <= 1'b0;
    end else begin
      // Start flag is a one-cycle copy of the decoder strobe
      frame_start_q <= sof_valid;
      if (sof_valid) begin
        frame_number_q <= sof_frame;
        frame_crc_error_q <= sof_crc_bad;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Global endpoint registers
  // ----------------------------------------------------------------------
  // Select and FIFO clear bits; the all-ones select is kept off by software
  // A select of all ones is stored as written but reads back zeroes
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      endpoint_select_q <= 3'h0;
      fifo_clear_q <= 7'h00;
    end else if (wr) begin
      if (avs_address == ADDR_ENDPOINT_SELECT)
        endpoint_select_q <= wd[2:0];
      if (avs_address == ADDR_ENDPOINT_FIFO_RESET)
        fifo_clear_q <= wd[6:0];
    end
  end

  // ----------------------------------------------------------------------
  // Per-endpoint state
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < NUM_EP; i++) begin : g_ep
    logic me;
    logic hit;
    logic in_fifo_rst;
    // Register access and engine events are matched separately
    assign me = (sel == 3'(i));
    assign hit = (ev_ep == 3'(i));
    assign in_fifo_rst = fifo_clear_q[i];

    // Cancel is written after request so a write with both bits set
    // leaves the endpoint unstalled; the toggle reset is a pulse that
    // lives for one cycle only
    // Control register: stall, toggle reset, enable
    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        stall_q[i] <= 1'b0;
        toggle_zero_q[i] <= 1'b0;
        enable_q[i] <= 1'b0;
      end else begin
        toggle_zero_q[i] <= 1'b0;
        // Bus reset clears enables; a write in that cycle still wins
        if (usb_bus_reset)
          enable_q[i] <= 1'b0;
        if (wr && me && avs_address == ADDR_ENDPOINT_CONTROL) begin
          if (wd[STALL_REQUEST_BIT])
            stall_q[i] <= 1'b1;
          if (wd[STALL_CANCEL_BIT])
            stall_q[i] <= 1'b0;
          toggle_zero_q[i] <= wd[TOGGLE_RESET_BIT];
          enable_q[i] <= wd[ENDPOINT_ENABLE_BIT];
        end
        // A fresh SETUP ends a stall even on the same cycle as a request
        if (ev_setup && hit)
          stall_q[i] <= 1'b0;
      end
    end

    // The fit is judged on the written fields, not the stored ones, so
    // config_valid is right in the same cycle as the new size
    // Configuration registers and the fit check on claim
    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        kind_q[i] <= KIND_CONTROL;
        dir_q[i] <= 1'b0;
        capacity_q[i] <= 3'h0;
        banks_q[i] <= 2'h0;
        claim_q[i] <= 1'b0;
        cfg_ok_q[i] <= 1'b0;
      end else if (wr && me) begin
        if (avs_address == ADDR_ENDPOINT_CONFIG_TYPE) begin
          kind_q[i] <= wd[ENDPOINT_KIND_LSB +: 2];
          dir_q[i] <= wd[ENDPOINT_DIRECTION_BIT];
        end
        if (avs_address == ADDR_ENDPOINT_CONFIG_SIZE) begin
          capacity_q[i] <= wd[ENDPOINT_CAPACITY_LSB +: 3];
          banks_q[i] <= wd[BANK_COUNT_LSB +: 2];
          claim_q[i] <= wd[MEMORY_CLAIM_BIT];
          // Releasing the memory also drops the fit result
          if (wd[MEMORY_CLAIM_BIT])
            cfg_ok_q[i] <= cfg_fits(3'(i), wd[ENDPOINT_CAPACITY_LSB +: 3],
                                    wd[BANK_COUNT_LSB +: 2]);
          else
            cfg_ok_q[i] <= 1'b0;
        end
      end
    end

    // Iso flow flags: hardware set wins over a software clear
    // Events on other kinds are dropped; the engine may report them freely
    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        overrun_q[i] <= 1'b0;
        starve_q[i] <= 1'b0;
      end else begin
        if (wr && me && avs_address == ADDR_ENDPOINT_STATUS_MAIN) begin
          if (!wd[ISO_OVERRUN_BIT])
            overrun_q[i] <= 1'b0;
          if (!wd[ISO_STARVE_BIT])
            starve_q[i] <= 1'b0;
        end
        // Set after the clear so a same-cycle event is never lost
        if (ev_overrun && hit && kind_q[i] == KIND_ISO)
          overrun_q[i] <= 1'b1;
        if (ev_starve && hit && kind_q[i] == KIND_ISO)
          starve_q[i] <= 1'b1;
      end
    end

    // Bank bookkeeping, toggle and control direction
    // A FIFO clear holds every bank field at zero while it stands; the
    // control direction is kept, as it belongs to the last SETUP only.
    // Fill and free in one cycle count as a fill, or as a free when two banks
    // are already busy; the engine never does both on one endpoint at once.
    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        toggle_q[i] <= 1'b0;
        busy_q[i] <= 2'h0;
        ctrl_dir_q[i] <= 1'b0;
        active_bank_q[i] <= 1'b0;
        handover_q[i] <= 1'b0;
        release_q[i] <= 1'b0;
      end else if (in_fifo_rst) begin
        toggle_q[i] <= 1'b0;
        busy_q[i] <= 2'h0;
        active_bank_q[i] <= 1'b0;
        handover_q[i] <= 1'b0;
        release_q[i] <= 1'b0;
      end else begin
        release_q[i] <= 1'b0;
        if (toggle_zero_q[i])
          toggle_q[i] <= 1'b0;
        else if (ev_toggle_valid && hit)
          toggle_q[i] <= ev_toggle;
        if (ev_setup && hit)
          ctrl_dir_q[i] <= ev_setup_dir_in;
        if (ev_bank_filled && hit && busy_q[i] != BUSY_TWO)
          busy_q[i] <= busy_q[i] + 2'h1;
        else if (ev_bank_freed && hit && busy_q[i] != 2'h0)
          busy_q[i] <= busy_q[i] - 2'h1;
        // Software clear hands the bank over; double-banked non-control endpoints also swap to the other bank
        if (wr && me && avs_address == ADDR_ENDPOINT_FLAGS &&
            !wd[BANK_HANDOVER_BIT] && handover_q[i]) begin
          handover_q[i] <= 1'b0;
          release_q[i] <= 1'b1;
          if (banks_q[i] == BANKS_DOUBLE && kind_q[i] != KIND_CONTROL)
            active_bank_q[i] <= ~active_bank_q[i];
        end
        // A new packet sets the handover bit again even on a clear cycle
        if ((ev_bank_filled || ev_setup) && hit)
          handover_q[i] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Avalon-MM read path and handshake
  // ----------------------------------------------------------------------
  // Reads of the endpoint registers show the selected endpoint only
  // Read data is zero outside the answer cycle, so a master that
  // samples late sees zero rather than a stale word.
  // The forbidden select makes every register read zero; no endpoint
  // storage is indexed past its end.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 32'h0000_0000;
      wait_q <= 1'b1;
    end else begin
      // Waitrequest low for exactly the cycle after a taken request
      wait_q <= ~acc;
      rdata_q <= 32'h0000_0000;
      if (acc && avs_read && sel != ENDPOINT_SELECT_FORBIDDEN) begin
        unique case (avs_address)
          ADDR_FRAME_NUMBER_HIGH: rdata_q[2:0] <= frame_number_q[10:8];
          ADDR_FRAME_NUMBER_LOW: rdata_q[7:0] <= frame_number_q[7:0];
          ADDR_FRAME_CRC_STATUS:
            rdata_q[FRAME_CRC_ERROR_BIT] <= frame_crc_error_q;
          ADDR_ENDPOINT_SELECT: rdata_q[2:0] <= endpoint_select_q;
          ADDR_ENDPOINT_FIFO_RESET: rdata_q[6:0] <= fifo_clear_q;
          ADDR_ENDPOINT_CONTROL: begin
            rdata_q[STALL_REQUEST_BIT] <= stall_q[sel];
            rdata_q[ENDPOINT_ENABLE_BIT] <= enable_q[sel];
          end
          ADDR_ENDPOINT_CONFIG_TYPE: begin
            rdata_q[ENDPOINT_KIND_LSB +: 2] <= kind_q[sel];
            rdata_q[ENDPOINT_DIRECTION_BIT] <= dir_q[sel];
          end
          ADDR_ENDPOINT_CONFIG_SIZE: begin
            rdata_q[ENDPOINT_CAPACITY_LSB +: 3] <= capacity_q[sel];
            rdata_q[BANK_COUNT_LSB +: 2] <= banks_q[sel];
            rdata_q[MEMORY_CLAIM_BIT] <= claim_q[sel];
          end
          ADDR_ENDPOINT_STATUS_MAIN: begin
            rdata_q[CONFIG_VALID_BIT] <= cfg_ok_q[sel];
            rdata_q[ISO_OVERRUN_BIT] <= overrun_q[sel];
            rdata_q[ISO_STARVE_BIT] <= starve_q[sel];
            rdata_q[TOGGLE_STATUS_LSB] <= toggle_q[sel];
            rdata_q[1:0] <= busy_q[sel];
          end
          // Active bank is forced to zero on control endpoints
          ADDR_ENDPOINT_STATUS_AUX: begin
            rdata_q[CONTROL_STAGE_DIR_BIT] <= ctrl_dir_q[sel];
            rdata_q[0] <= (kind_q[sel] != KIND_CONTROL) &
                          active_bank_q[sel];
          end
          ADDR_ENDPOINT_FLAGS:
            rdata_q[BANK_HANDOVER_BIT] <= handover_q[sel];
          default: rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, all registered
  // ----------------------------------------------------------------------
  // Each output is a plain copy of a flip-flop, no logic after it
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign frame_start_flag = frame_start_q;
  assign endpoint_fifo_clear = fifo_clear_q;
  assign stall_active = 7'(stall_q);
  assign toggle_zero_req = 7'(toggle_zero_q);
  assign bank_release = 7'(release_q);
  assign ep_enabled = 7'(enable_q);

endmodule : usbepr_top

// ==== include/usbepr_pkg.sv ====
// Package of register offsets, fields and constants for the endpoint registers
package usbepr_pkg;
  // ----------------------------------------------------------------------
  // Register byte addresses (word aligned)
  // ----------------------------------------------------------------------
  localparam logic [5:0] ADDR_FRAME_NUMBER_HIGH = 6'h00;
  localparam logic [5:0] ADDR_FRAME_NUMBER_LOW = 6'h04;
  localparam logic [5:0] ADDR_FRAME_CRC_STATUS = 6'h08;
  localparam logic [5:0] ADDR_ENDPOINT_SELECT = 6'h0c;
  localparam logic [5:0] ADDR_ENDPOINT_FIFO_RESET = 6'h10;
  localparam logic [5:0] ADDR_ENDPOINT_CONTROL = 6'h14;
  localparam logic [5:0] ADDR_ENDPOINT_CONFIG_TYPE = 6'h18;
  localparam logic [5:0] ADDR_ENDPOINT_CONFIG_SIZE = 6'h1c;
  localparam logic [5:0] ADDR_ENDPOINT_STATUS_MAIN = 6'h20;
  localparam logic [5:0] ADDR_ENDPOINT_STATUS_AUX = 6'h24;
  localparam logic [5:0] ADDR_ENDPOINT_FLAGS = 6'h28;
  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int FRAME_CRC_ERROR_BIT = 4;
  localparam int STALL_REQUEST_BIT = 5;
  localparam int STALL_CANCEL_BIT = 4;
  localparam int TOGGLE_RESET_BIT = 3;
  localparam int ENDPOINT_ENABLE_BIT = 0;
  localparam int ENDPOINT_KIND_LSB = 6;
  localparam int ENDPOINT_DIRECTION_BIT = 0;
  localparam int ENDPOINT_CAPACITY_LSB = 4;
  localparam int BANK_COUNT_LSB = 2;
  localparam int MEMORY_CLAIM_BIT = 1;
  localparam int CONFIG_VALID_BIT = 7;
  localparam int ISO_OVERRUN_BIT = 6;
  localparam int ISO_STARVE_BIT = 5;
  localparam int TOGGLE_STATUS_LSB = 2;
  localparam int CONTROL_STAGE_DIR_BIT = 2;
  localparam int BANK_HANDOVER_BIT = 7;
  // ----------------------------------------------------------------------
  // Encodings and sizes
  // ----------------------------------------------------------------------
  localparam logic [2:0] ENDPOINT_SELECT_FORBIDDEN = 3'h7;
  localparam logic [1:0] KIND_CONTROL = 2'h0;
  localparam logic [1:0] KIND_ISO = 2'h1;
  localparam logic [1:0] KIND_BULK = 2'h2;
  localparam logic [1:0] KIND_INTERRUPT = 2'h3;
  localparam logic [2:0] CAPACITY_MAX_ANY = 3'h3;
  localparam logic [2:0] CAPACITY_MAX_BIG = 3'h5;
  localparam logic [2:0] BIG_ENDPOINT = 3'h1;
  localparam logic [1:0] BANKS_DOUBLE = 2'h1;
  localparam logic [1:0] BUSY_TWO = 2'h2;
  localparam logic [3:0] CAPACITY_SHIFT = 4'h3;
  localparam int FIFO_BYTES = 832;
  localparam int NUM_ENDPOINTS = 7;
  localparam logic [7:0] DATA_ZERO = 8'h00;
endpackage : usbepr_pkg

// ==== test/usbepr_chk_sva.sv ====
// Checker of bus handshake and engine outputs of the endpoint registers
`timescale 1ns/10ps
module usbepr_chk
  import usbepr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic sof_valid,
  input wire logic [2:0] ev_ep,
  input wire logic ev_setup,
  input wire logic usb_bus_reset,
  input wire logic frame_start_flag,
  input wire logic [6:0] endpoint_fifo_clear,
  input wire logic [6:0] stall_active,
  input wire logic [6:0] toggle_zero_req,
  input wire logic [6:0] bank_release,
  input wire logic [6:0] ep_enabled
);
  // ------------------------------
  // Sequences and assertions
  // ------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Request seen while the slave still holds waitrequest
  sequence s_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_tog_wr;
    s_taken ##0 (avs_write && avs_address == ADDR_ENDPOINT_CONTROL
      && avs_writedata[TOGGLE_RESET_BIT]);
  endsequence
  chk_ack_latency: assert property (
    s_taken |=> !avs_waitrequest) else $error("answer late");
  chk_ack_single: assert property (
    !avs_waitrequest |=> avs_waitrequest) else $error("answer held");
  chk_rdata_idle: assert property (
    avs_waitrequest |-> avs_readdata == 32'h0) else $error("stale data");
  chk_sof_flag: assert property (
    sof_valid |=> frame_start_flag) else $error("frame flag missing");
  // Setup must win over a pending stall on the control endpoint
  chk_setup_stall: assert property (
    ev_setup && ev_ep == 3'h0 |-> ##[1:2] !stall_active[0])
    else $error("stall kept after setup");
  chk_toggle_pulse: assert property (
    s_tog_wr |-> ##[1:2] toggle_zero_req != 7'h00)
    else $error("toggle reset lost");
  chk_toggle_once: assert property (
    toggle_zero_req != 7'h00 |=> toggle_zero_req == 7'h00)
    else $error("toggle reset stuck");
  chk_release_once: assert property (
    bank_release != 7'h00 |=> bank_release == 7'h00)
    else $error("bank release stuck");
  chk_bus_reset: assert property (
    usb_bus_reset [*2] |-> ep_enabled == 7'h00)
    else $error("enable kept in bus reset");
  // FIFO clear only moves after a software write
  chk_fifo_cause: assert property (
    $changed(endpoint_fifo_clear) |-> $past(avs_write) || $past(avs_write, 2))
    else $error("fifo clear moved alone");
endmodule : usbepr_chk
bind usbepr_top usbepr_chk u_chk (.*);

// ==== test/usbepr_host_model.sv ====
// Behavioural USB engine and host traffic beside the register block
`timescale 1ns/10ps
module usbepr_host_model (
  input wire logic sys_clk,
  output logic sof_valid,
  output logic sof_crc_bad,
  output logic [10:0] sof_frame,
  output logic [2:0] ev_ep,
  output logic ev_setup,
  output logic ev_setup_dir_in,
  output logic ev_bank_filled,
  output logic ev_bank_freed,
  output logic ev_toggle,
  output logic ev_toggle_valid,
  output logic ev_overrun,
  output logic ev_starve,
  output logic usb_bus_reset
);
  logic [5:0] evk = 6'h00;
  // ------------------------------
  // Event strobes and tasks
  // ------------------------------
  assign {ev_setup, ev_bank_filled, ev_bank_freed, ev_toggle_valid,
    ev_overrun, ev_starve} = evk;
  // Quiet engine at time zero
  initial begin
    {sof_valid, sof_crc_bad, sof_frame, ev_ep} = 16'h0000;
    {ev_setup_dir_in, ev_toggle, usb_bus_reset} = 3'h0;
  end
  // A corrupted frame still carries its number; stale lines flip afterwards
  task automatic sof(input logic [10:0] f, input logic bad);
    @(posedge sys_clk);
    sof_valid <= 1'b1;
    sof_frame <= f;
    sof_crc_bad <= bad;
    @(posedge sys_clk);
    sof_valid <= 1'b0;
    sof_frame <= ~f;
    sof_crc_bad <= ~bad;
  endtask : sof
  // One endpoint event pulse; qualifiers are garbled once it ends
  task automatic ev(input logic [2:0] ep, input logic [5:0] k,
                    input logic v);
    @(posedge sys_clk);
    ev_ep <= ep;
    ev_setup_dir_in <= v;
    ev_toggle <= v;
    evk <= k;
    @(posedge sys_clk);
    ev_ep <= ~ep;
    ev_setup_dir_in <= ~v;
    ev_toggle <= ~v;
    evk <= 6'h00;
  endtask : ev
  task automatic bus_reset();
    @(posedge sys_clk);
    usb_bus_reset <= 1'b1;
    repeat (3) @(posedge sys_clk);
    usb_bus_reset <= 1'b0;
  endtask : bus_reset
endmodule : usbepr_host_model

// ==== test/usbepr_tb_top.sv ====
// Self-checking bench of the endpoint register block
`timescale 1ns/10ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  error_cnt++; $display("BAD %s expected %h seen %h", n, e, g); end end
module usbepr_tb_top;
  import usbepr_pkg::*;
  localparam logic [5:0] SEL = ADDR_ENDPOINT_SELECT,
    CTL = ADDR_ENDPOINT_CONTROL, TYP = ADDR_ENDPOINT_CONFIG_TYPE,
    SIZ = ADDR_ENDPOINT_CONFIG_SIZE, STM = ADDR_ENDPOINT_STATUS_MAIN,
    AUX = ADDR_ENDPOINT_STATUS_AUX, FLG = ADDR_ENDPOINT_FLAGS;
  localparam logic [5:0] EV_SETUP = 6'h20, EV_FILL = 6'h10,
    EV_FREE = 6'h08, EV_TOG = 6'h04, EV_OVR = 6'h02, EV_STV = 6'h01;
  localparam logic W = 1'b0, R = 1'b1;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata, mon_e;
  logic avs_waitrequest, frame_start_flag, sof_valid, sof_crc_bad;
  logic ev_setup, ev_setup_dir_in, ev_bank_filled, ev_bank_freed;
  logic ev_toggle, ev_toggle_valid, ev_overrun, ev_starve, usb_bus_reset;
  logic [10:0] sof_frame, frm;
  logic [2:0] ev_ep;
  logic [6:0] endpoint_fifo_clear, stall_active, toggle_zero_req;
  logic [6:0] bank_release, ep_enabled;
  logic [5:0] mon_a;
  logic [31:0] exp_q[$];
  logic [5:0] adr_q[$];
  int error_cnt = 0;
  int cmp_count = 0;
  int sof_seen = 0, tzr_seen = 0, rel_seen = 0;
  logic [2:0] cap_t[7] = '{3'h3, 3'h5, 3'h4, 3'h2, 3'h1, 3'h0, 3'h3};
  logic [1:0] bank_t[7] = '{2'h1, 2'h1, 2'h0, 2'h2, 2'h0, 2'h1, 2'h0};
  usbepr_top uut (.*);
  usbepr_host_model p (.*);
  always #10 sys_clk = ~sys_clk;
  // ------------------------------
  // Bus driver, monitor and helpers
  // ------------------------------
  // Oldest noted value is compared whenever a read is answered
  always @(posedge sys_clk) begin
    if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
      mon_e = exp_q.pop_front();
      mon_a = adr_q.pop_front();
      `CHK($sformatf("reg_%h", mon_a), mon_e, avs_readdata)
    end
    // One-cycle engine pulses are counted here, checked at the end
    if (frame_start_flag === 1'b1) sof_seen++;
    if (toggle_zero_req === 7'h01) tzr_seen++;
    if (bank_release === 7'h20) rel_seen++;
  end
  // One access held until waitrequest is seen low; a read notes its byte
  task automatic bus(input logic rd, input logic [5:0] a,
                     input logic [7:0] d);
    int n;
    if (rd) begin
      exp_q.push_back({24'h0, d});
      adr_q.push_back(a);
    end
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= rd ? 32'h0 : {24'h0, d};
    avs_read <= rd;
    avs_write <= !rd;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      error_cnt++;
      finish_test();
    end
  endtask : bus
  task automatic settle();
    repeat (3) @(posedge sys_clk);
  endtask : settle
  // Size and banks must fit the shared FIFO; big sizes only on endpoint 1
  function automatic logic fits(input int ep);
    int by;
    by = (8 << cap_t[ep]) * (bank_t[ep][0] ? 2 : 1);
    return (cap_t[ep] <= 3 || (ep == 1 && cap_t[ep] <= 5))
      && !bank_t[ep][1] && by <= FIFO_BYTES;
  endfunction : fits
  task automatic finish_test();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    void'($urandom(32'heb0e));
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (int a = 0; a < 16; a++) bus(R, 6'(a * 4), 8'h00);
    for (int i = 0; i < 4; i++) begin
      frm = 11'($urandom);
      p.sof(frm, i[0]);
      bus(R, ADDR_FRAME_NUMBER_HIGH, {5'h00, frm[10:8]});
      bus(R, ADDR_FRAME_NUMBER_LOW, frm[7:0]);
      bus(R, ADDR_FRAME_CRC_STATUS, {3'h0, i[0], 4'h0});
    end
    // Configure every endpoint, claim memory only after size is set
    for (int ep = 0; ep < NUM_ENDPOINTS; ep++) begin
      bus(W, SEL, 8'(ep));
      bus(W, CTL, 8'h01);
      bus(W, TYP, {ep[1:0], 5'h00, ep[1]});
      bus(W, SIZ, {1'b0, cap_t[ep], bank_t[ep], 2'h0});
      bus(W, SIZ, {1'b0, cap_t[ep], bank_t[ep], 2'h2});
    end
    settle();
    `CHK("ep_enabled", 7'h7f, ep_enabled)
    for (int ep = NUM_ENDPOINTS - 1; ep >= 0; ep--) begin
      bus(W, SEL, 8'(ep));
      bus(R, TYP, {ep[1:0], 5'h00, ep[1]});
      bus(R, SIZ, {1'b0, cap_t[ep], bank_t[ep], 2'h2});
      bus(R, STM, {fits(ep), 7'h00});
    end
    // Stall, cancel and toggle reset on the control endpoint
    bus(W, CTL, 8'h21);
    bus(W, CTL, 8'h01);
    bus(R, CTL, 8'h21);
    settle();
    `CHK("stall_active", 7'h01, stall_active)
    p.ev(3'h0, EV_SETUP, 1'b1);
    bus(R, CTL, 8'h01);
    bus(R, AUX, 8'h04);
    p.ev(3'h0, EV_SETUP, 1'b0);
    bus(R, AUX, 8'h00);
    bus(W, CTL, 8'h21);
    bus(W, CTL, 8'h11);
    bus(R, CTL, 8'h01);
    bus(W, CTL, 8'h09);
    bus(R, CTL, 8'h01);
    p.ev(3'h0, EV_TOG, 1'b1);
    bus(R, STM, 8'h84);
    bus(W, CTL, 8'h09);
    bus(R, STM, 8'h80);
    // Isochronous flow errors: ones ignored, zero clears
    bus(W, SEL, 8'h01);
    for (int i = 0; i < 2; i++) begin
      p.ev(3'h1, i ? EV_STV : EV_OVR, 1'b0);
      bus(R, STM, i ? 8'ha0 : 8'hc0);
      bus(W, STM, 8'hff);
      bus(R, STM, i ? 8'ha0 : 8'hc0);
      bus(W, STM, 8'h00);
      bus(R, STM, 8'h80);
    end
    // Double-banked OUT endpoint: fill, free, hand over
    bus(W, SEL, 8'h05);
    p.ev(3'h5, EV_FILL, 1'b0);
    p.ev(3'h5, EV_FILL, 1'b0);
    bus(R, STM, 8'h82);
    bus(R, FLG, 8'h80);
    p.ev(3'h5, EV_FREE, 1'b0);
    bus(R, STM, 8'h81);
    bus(W, FLG, 8'h00);
    bus(R, AUX, 8'h01);
    bus(W, ADDR_ENDPOINT_FIFO_RESET, 8'h24);
    bus(R, ADDR_ENDPOINT_FIFO_RESET, 8'h24);
    settle();
    `CHK("fifo_clear", 7'h24, endpoint_fifo_clear)
    bus(W, ADDR_ENDPOINT_FIFO_RESET, 8'h00);
    bus(R, STM, 8'h80);
    p.bus_reset();
    settle();
    `CHK("ep_enabled", 7'h00, ep_enabled)
    bus(W, SEL, 8'h00);
    bus(W, CTL, 8'h01);
    settle();
    `CHK("ep_enabled", 7'h01, ep_enabled)
    `CHK("frame_start", 4, sof_seen)
    `CHK("toggle_pulses", 2, tzr_seen)
    `CHK("bank_release", 1, rel_seen)
    finish_test();
  end
endmodule : usbepr_tb_top
